// >>> pss_pkg.sv
// Constants, register map and period table of the channel soft-start and trim block.
// Assumes a single 125 MHz clock and register access over APB with 32-bit data.
package pss_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_GRP = 8'h19;
    localparam logic [7:0] IDX_SSP = 8'h1A;
    localparam logic [7:0] IDX_TRIM = 8'h1B;
    localparam logic [7:0] IDX_ISTAT = 8'h30;
    localparam logic [7:0] IDX_IMASK = 8'h31;
    localparam logic [7:0] IDX_CTRL = 8'h32;

    localparam logic [7:0] GRP_RST = 8'h30;
    localparam logic [7:0] SSP_RST = 8'h00;
    localparam logic [7:0] TRIM_RST = 8'h82;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] GRP_WMASK = 8'h3F;
    localparam logic [7:0] SSP_WMASK = 8'h9F;
    localparam logic [7:0] CTRL_WMASK = 8'h01;

    localparam int NCH = 6;
    localparam int SSP_SE_BIT = 7;
    localparam int SSP_CODE_MSB = 4;
    localparam int SSP_EN_LSB = 3;
    localparam int TRIM_DONE_BIT = 6;
    localparam int TRIM_SEL_BIT = 1;
    localparam int CTRL_SD_BIT = 0;
    localparam int IRQ_TRIM = 0;
    localparam int IRQ_SOFT = 1;
    localparam int IRQ_W = 2;

    localparam int CLK_PERIOD_NS = 8;
    localparam int TENTH_MS_NS = 100000;
    localparam int CYC_PER_TENTH = TENTH_MS_NS / CLK_PERIOD_NS;
    localparam int TRIM_LOAD_CYC = 16;
    localparam int PER_W = 18;

    typedef enum logic {SOFT_IDLE, SOFT_RUN} pss_soft_t;
    typedef enum logic [1:0] {TRIM_OFF, TRIM_LOAD, TRIM_DONE} pss_trim_t;

    // Soft period in tenths of a millisecond for each enabled code.
    function automatic logic [PER_W-1:0] period_tenths(input logic [4:0] code);
        case (code)
            5'h08: period_tenths = 18'h000A5;
            5'h09: period_tenths = 18'h000EF;
            5'h0A: period_tenths = 18'h0013A;
            5'h0B: period_tenths = 18'h00194;
            5'h0C: period_tenths = 18'h0021B;
            5'h0D: period_tenths = 18'h002BF;
            5'h0E: period_tenths = 18'h003AE;
            5'h0F: period_tenths = 18'h004E9;
            5'h10: period_tenths = 18'h0066E;
            5'h11: period_tenths = 18'h0095A;
            5'h12: period_tenths = 18'h00C46;
            5'h13: period_tenths = 18'h00FC7;
            5'h14: period_tenths = 18'h0150A;
            5'h15: period_tenths = 18'h01B77;
            5'h16: period_tenths = 18'h024D1;
            5'h17: period_tenths = 18'h03116;
            5'h18: period_tenths = 18'h04381;
            5'h19: period_tenths = 18'h06230;
            5'h1A: period_tenths = 18'h080DF;
            5'h1B: period_tenths = 18'h0A5B1;
            5'h1C: period_tenths = 18'h0DCEC;
            5'h1D: period_tenths = 18'h1206D;
            5'h1E: period_tenths = 18'h1829D;
            5'h1F: period_tenths = 18'h2037C;
            default: period_tenths = 18'h00000;
        endcase
    endfunction

endpackage

// >>> pss_softstart.sv
// Soft period timer: a prescaler makes a tenth-millisecond enable, a second counter
// counts those enables. Assumes start is a one-cycle pulse from the same clock.
`timescale 1ns/1ps
`default_nettype none
module pss_softstart #(
    parameter int CYC_PER_TENTH = pss_pkg::CYC_PER_TENTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [pss_pkg::PER_W-1:0] tenths,
    output logic busy,
    output logic done
);
    logic [31:0] pre_ff;
    logic [pss_pkg::PER_W-1:0] cnt_ff;
    logic busy_ff;
    logic done_ff;
    logic tick;

    ////////////////////////////////////////////////////////////////////////////////
    // The prescaler restarts with each start so that every period is whole tenths.
    assign tick = busy_ff && (pre_ff == 32'(CYC_PER_TENTH - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_ff <= 32'h0;
        end else if (start || tick) begin
            pre_ff <= 32'h0;
        end else if (busy_ff) begin
            pre_ff <= pre_ff + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (start) begin
                cnt_ff <= tenths;
                busy_ff <= 1'b1;
            end else if (busy_ff && (cnt_ff == '0)) begin
                busy_ff <= 1'b0;
                done_ff <= 1'b1;
            end else if (tick) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end

    assign busy = busy_ff;
    assign done = done_ff;

endmodule
`default_nettype wire

// >>> pss_top.sv
// Channel shutdown group, soft start/stop timing and oscillator trim control.
// Assumes an APB master on pclk and a static factory trim word from fuse logic on pclk.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pss_top #(
    parameter int CYC_PER_TENTH = pss_pkg::CYC_PER_TENTH,
    parameter int TRIM_LOAD_CYC = pss_pkg::TRIM_LOAD_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] factory_trim_code,
    output logic [5:0] ch_active,
    output logic [5:0] ch_half_duty,
    output logic load_single_ended,
    output logic osc_trim_en,
    output logic [7:0] osc_trim_code,
    output logic irq
);
    logic [7:0] grp_ff, ssp_ff, trim_ff, ctrl_ff;
    logic [pss_pkg::IRQ_W-1:0] istat_ff, imask_ff;
    logic [31:0] prdata_ff;
    logic [5:0] applied_ff, tgt_lat_ff, trans_ff, target;
    logic [5:0] ch_active_ff, ch_half_ff;
    logic [7:0] trim_code_ff;
    logic [7:0] tcnt_ff;
    logic [pss_pkg::PER_W-1:0] per_tenths;
    logic per_en, ss_start, ss_busy, ss_done, trim_evt;
    logic wr, rd_setup, hit;
    pss_pkg::pss_soft_t soft_ff;
    pss_pkg::pss_trim_t trim_st_ff;

    function automatic logic is_reg(input logic [11:0] a, input logic [7:0] idx);
        is_reg = (a == {2'b00, idx, 2'b00});
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data captured in the setup cycle.
    // Unmapped addresses answer with an error, write nothing and read as zero.
    assign hit = is_reg(paddr, pss_pkg::IDX_GRP) || is_reg(paddr, pss_pkg::IDX_SSP)
        || is_reg(paddr, pss_pkg::IDX_TRIM) || is_reg(paddr, pss_pkg::IDX_ISTAT)
        || is_reg(paddr, pss_pkg::IDX_IMASK) || is_reg(paddr, pss_pkg::IDX_CTRL);
    assign wr = psel && penable && pwrite && hit;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
        end else if (rd_setup) begin
            prdata_ff <= 32'h0;
            if (is_reg(paddr, pss_pkg::IDX_GRP)) prdata_ff[7:0] <= grp_ff;
            if (is_reg(paddr, pss_pkg::IDX_SSP)) prdata_ff[7:0] <= ssp_ff;
            if (is_reg(paddr, pss_pkg::IDX_TRIM)) prdata_ff[7:0] <= trim_ff;
            if (is_reg(paddr, pss_pkg::IDX_ISTAT)) prdata_ff[pss_pkg::IRQ_W-1:0] <= istat_ff;
            if (is_reg(paddr, pss_pkg::IDX_IMASK)) prdata_ff[pss_pkg::IRQ_W-1:0] <= imask_ff;
            if (is_reg(paddr, pss_pkg::IDX_CTRL)) prdata_ff[7:0] <= ctrl_ff;
        end
    end
    assign prdata = prdata_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers; reserved bits are masked off on write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grp_ff <= pss_pkg::GRP_RST;
            ssp_ff <= pss_pkg::SSP_RST;
            ctrl_ff <= pss_pkg::CTRL_RST;
            imask_ff <= '0;
        end else if (wr) begin
            if (is_reg(paddr, pss_pkg::IDX_GRP)) grp_ff <= pwdata[7:0] & pss_pkg::GRP_WMASK;
            if (is_reg(paddr, pss_pkg::IDX_SSP)) ssp_ff <= pwdata[7:0] & pss_pkg::SSP_WMASK;
            if (is_reg(paddr, pss_pkg::IDX_CTRL)) ctrl_ff <= pwdata[7:0] & pss_pkg::CTRL_WMASK;
            if (is_reg(paddr, pss_pkg::IDX_IMASK)) imask_ff <= pwdata[pss_pkg::IRQ_W-1:0];
        end
    end

    // Sticky events; a set in the same cycle as a write-one clear wins.
    // The interrupt is a plain level, so software must clear or mask the flag to drop it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_ff <= '0;
        end else begin
            istat_ff[pss_pkg::IRQ_TRIM] <= trim_evt || (istat_ff[pss_pkg::IRQ_TRIM]
                && !(wr && is_reg(paddr, pss_pkg::IDX_ISTAT) && pwdata[pss_pkg::IRQ_TRIM]));
            istat_ff[pss_pkg::IRQ_SOFT] <= ss_done || (istat_ff[pss_pkg::IRQ_SOFT]
                && !(wr && is_reg(paddr, pss_pkg::IDX_ISTAT) && pwdata[pss_pkg::IRQ_SOFT]));
        end
    end
    assign irq = |(istat_ff & imask_ff);

    ////////////////////////////////////////////////////////////////////////////////
    // Channel activity with soft start/stop.
    assign target = ctrl_ff[pss_pkg::CTRL_SD_BIT] ? 6'h00 : grp_ff[5:0];
    assign per_en = |ssp_ff[pss_pkg::SSP_CODE_MSB:pss_pkg::SSP_EN_LSB];
    assign per_tenths = pss_pkg::period_tenths(ssp_ff[pss_pkg::SSP_CODE_MSB:0]);
    // A target change during a running period restarts it, so no channel gets a short one.
    assign ss_start = per_en && (soft_ff == pss_pkg::SOFT_IDLE ? (target != applied_ff)
        : (target != tgt_lat_ff));

    pss_softstart #(.CYC_PER_TENTH(CYC_PER_TENTH)) u_soft (
        .pclk(pclk),
        .presetn(presetn),
        .start(ss_start),
        .tenths(per_tenths),
        .busy(ss_busy),
        .done(ss_done)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_ff <= pss_pkg::SOFT_IDLE;
            applied_ff <= 6'h00;
            tgt_lat_ff <= 6'h00;
            trans_ff <= 6'h00;
        end else begin
            case (soft_ff)
                pss_pkg::SOFT_IDLE: begin
                    if (ss_start) begin
                        soft_ff <= pss_pkg::SOFT_RUN;
                        tgt_lat_ff <= target;
                        trans_ff <= target ^ applied_ff;
                    end else if (!per_en) begin
                        applied_ff <= target;
                    end
                end
                pss_pkg::SOFT_RUN: begin
                    if (ss_start) begin
                        tgt_lat_ff <= target;
                        trans_ff <= trans_ff | (target ^ tgt_lat_ff);
                    end else if (ss_done) begin
                        soft_ff <= pss_pkg::SOFT_IDLE;
                        applied_ff <= tgt_lat_ff;
                        trans_ff <= 6'h00;
                    end
                end
                default: soft_ff <= pss_pkg::SOFT_IDLE;
            endcase
        end
    end

    // Transitioning channels switch at 50% duty for the whole period.
    // Both outputs come from one register stage, so they trail the applied set by a cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch_active_ff <= 6'h00;
            ch_half_ff <= 6'h00;
        end else begin
            ch_active_ff <= applied_ff | trans_ff;
            ch_half_ff <= trans_ff;
        end
    end
    assign ch_active = ch_active_ff;
    assign ch_half_duty = ch_half_ff;
    assign load_single_ended = ssp_ff[pss_pkg::SSP_SE_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Oscillator trim: selecting factory trim loads the stored word, no measurement.
    // The load wait only models fetching the stored word; nothing is calibrated here.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_st_ff <= pss_pkg::TRIM_OFF;
            tcnt_ff <= 8'h00;
            trim_code_ff <= 8'h00;
        end else begin
            case (trim_st_ff)
                pss_pkg::TRIM_OFF: begin
                    if (!trim_ff[pss_pkg::TRIM_SEL_BIT]) begin
                        trim_st_ff <= pss_pkg::TRIM_LOAD;
                        tcnt_ff <= 8'(TRIM_LOAD_CYC - 1);
                    end
                end
                pss_pkg::TRIM_LOAD: begin
                    if (trim_ff[pss_pkg::TRIM_SEL_BIT]) begin
                        trim_st_ff <= pss_pkg::TRIM_OFF;
                    end else if (tcnt_ff == 8'h00) begin
                        trim_st_ff <= pss_pkg::TRIM_DONE;
                        trim_code_ff <= factory_trim_code;
                    end else begin
                        tcnt_ff <= tcnt_ff - 8'h01;
                    end
                end
                pss_pkg::TRIM_DONE: begin
                    if (trim_ff[pss_pkg::TRIM_SEL_BIT]) trim_st_ff <= pss_pkg::TRIM_OFF;
                end
                default: trim_st_ff <= pss_pkg::TRIM_OFF;
            endcase
        end
    end
    assign trim_evt = (trim_st_ff == pss_pkg::TRIM_LOAD) && (tcnt_ff == 8'h00)
        && !trim_ff[pss_pkg::TRIM_SEL_BIT];

    // Only the select bit is writable; the done bit mirrors the trim state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_ff <= pss_pkg::TRIM_RST;
        end else begin
            if (wr && is_reg(paddr, pss_pkg::IDX_TRIM)) begin
                trim_ff[pss_pkg::TRIM_SEL_BIT] <= pwdata[pss_pkg::TRIM_SEL_BIT];
            end
            trim_ff[pss_pkg::TRIM_DONE_BIT] <= (trim_st_ff == pss_pkg::TRIM_DONE);
        end
    end
    assign osc_trim_en = (trim_st_ff == pss_pkg::TRIM_DONE);
    assign osc_trim_code = trim_code_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks. Sequences describe the trim steps; properties watch design state and the APB inputs.
    // Attempts in the reset release cycle are excluded where reset values would mislead.
    sequence s_trim_sel;
        wr && is_reg(paddr, pss_pkg::IDX_TRIM) && !pwdata[pss_pkg::TRIM_SEL_BIT]
            && trim_st_ff == pss_pkg::TRIM_OFF;
    endsequence
    sequence s_trim_fin;
        trim_st_ff == pss_pkg::TRIM_DONE && osc_trim_code == factory_trim_code;
    endsequence

    a_grp_reset_val: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> grp_ff == pss_pkg::GRP_RST)
        else $error("group register not at reset value");
    a_rsv_bits_zero: assert property (@(posedge pclk) disable iff (!presetn)
        grp_ff[7:6] == 2'b00 && ssp_ff[6:5] == 2'b00 && trim_ff[7] && !trim_ff[0])
        else $error("reserved bit changed");
    a_no_period_apply: assert property (@(posedge pclk) disable iff (!presetn)
        presetn && soft_ff == pss_pkg::SOFT_IDLE && !per_en && !wr
            |=> applied_ff == $past(target))
        else $error("channels not applied at once without period");
    a_half_duty_win: assert property (@(posedge pclk) disable iff (!presetn)
        soft_ff == pss_pkg::SOFT_IDLE && ss_start |=> ##1 ch_half_duty == $past(trans_ff)
            && ch_half_duty != 6'h00)
        else $error("transition channels not at half duty");
    a_shutdown_all: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_ff[pss_pkg::CTRL_SD_BIT] && soft_ff == pss_pkg::SOFT_RUN && ss_done && !ss_start
            |=> applied_ff == 6'h00)
        else $error("system shutdown bit ignored");
    a_active_follows: assert property (@(posedge pclk) disable iff (!presetn)
        soft_ff == pss_pkg::SOFT_RUN && ss_done && !ss_start |=> applied_ff == $past(tgt_lat_ff))
        else $error("channels not applied after period");
    a_se_mode_wr: assert property (@(posedge pclk) disable iff (!presetn)
        wr && is_reg(paddr, pss_pkg::IDX_SSP) |=> load_single_ended == $past(pwdata[7]))
        else $error("load mode bit not taken");
    a_period_ends: assert property (@(posedge pclk) disable iff (!presetn)
        ssp_ff[4:0] == 5'h08 |-> per_tenths == 18'h000A5
            && pss_pkg::period_tenths(5'h1F) == 18'h2037C)
        else $error("period table end codes wrong");
    a_period_mid: assert property (@(posedge pclk) disable iff (!presetn)
        ssp_ff[4:0] == 5'h0F |-> per_tenths == 18'h004E9)
        else $error("period code 0F wrong");
    a_period_high: assert property (@(posedge pclk) disable iff (!presetn)
        ssp_ff[4:0] == 5'h10 |-> per_tenths == 18'h0066E
            && pss_pkg::period_tenths(5'h1E) == 18'h1829D)
        else $error("period code 10 or 1E wrong");
    a_period_c11: assert property (@(posedge pclk) disable iff (!presetn)
        ssp_ff[4:0] == 5'h11 |-> per_tenths == 18'h0095A
            && pss_pkg::period_tenths(5'h1D) == 18'h1206D)
        else $error("period code 11 or 1D wrong");
    a_trim_sequence: assert property (@(posedge pclk) disable iff (!presetn)
        s_trim_sel ##1 !trim_ff[pss_pkg::TRIM_SEL_BIT] [*2] |-> ##[0:20] s_trim_fin)
        else $error("factory trim not applied in time");
    a_trim_done_ro: assert property (@(posedge pclk) disable iff (!presetn)
        trim_st_ff == pss_pkg::TRIM_OFF ##1 trim_st_ff == pss_pkg::TRIM_OFF
            |-> !trim_ff[pss_pkg::TRIM_DONE_BIT])
        else $error("trim done flag set without trimming");

    // Event flags: the event wins over a write-one clear in the same cycle. Also no half duty while idle.
    a_trim_evt_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        trim_evt |=> istat_ff[pss_pkg::IRQ_TRIM])
        else $error("trim event not recorded");
    a_soft_evt_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        ss_done |=> istat_ff[pss_pkg::IRQ_SOFT])
        else $error("period end event not recorded");
    a_idle_full_duty: assert property (@(posedge pclk) disable iff (!presetn)
        soft_ff == pss_pkg::SOFT_IDLE |=> ch_half_duty == 6'h00)
        else $error("half duty outside a period");

    // Trim state and its register view.
    a_trim_done_flag: assert property (@(posedge pclk) disable iff (!presetn)
        trim_st_ff == pss_pkg::TRIM_DONE |=> trim_ff[pss_pkg::TRIM_DONE_BIT])
        else $error("trim done flag not set");
    a_trim_deselect: assert property (@(posedge pclk) disable iff (!presetn)
        trim_st_ff != pss_pkg::TRIM_OFF && trim_ff[pss_pkg::TRIM_SEL_BIT]
            |=> trim_st_ff == pss_pkg::TRIM_OFF)
        else $error("factory trim not released");
    a_trim_sel_rst: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> trim_ff[pss_pkg::TRIM_SEL_BIT] && !osc_trim_en)
        else $error("factory trim selected after reset");
    a_trim_code_hold: assert property (@(posedge pclk) disable iff (!presetn)
        trim_st_ff == pss_pkg::TRIM_DONE |=> $stable(osc_trim_code))
        else $error("trim word changed while applied");

    // Register bus side effects.
    a_grp_read_data: assert property (@(posedge pclk) disable iff (!presetn)
        rd_setup && is_reg(paddr, pss_pkg::IDX_GRP) |=> prdata[7:0] == $past(grp_ff))
        else $error("group register read wrong");
    a_unmapped_wr: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pwrite && !hit |=> $stable(grp_ff) && $stable(ssp_ff))
        else $error("unmapped write changed a register");

endmodule
`default_nettype wire

// >>> pwm_shutdown_softstart_trim_tb_top.sv
// Self-checking bench for the channel group, soft period, trim and interrupt logic.
// Assumes the package and design files are compiled first; the bench is the APB master.
`timescale 1ns/1ps
`default_nettype none
module pwm_shutdown_softstart_trim_tb_top;
    // A tenth of a millisecond is shortened to four clocks so the long periods fit the run.
    localparam int CPT = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0] factory_trim_code = 8'h5A;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] ch_active;
    logic [5:0] ch_half_duty;
    logic load_single_ended;
    logic osc_trim_en;
    logic [7:0] osc_trim_code;
    logic irq;
    int num_errors = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic err;
    logic [5:0] grp_v;

    always #4 pclk = ~pclk;

    pss_top #(.CYC_PER_TENTH(CPT), .TRIM_LOAD_CYC(16)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .factory_trim_code(factory_trim_code), .ch_active(ch_active),
        .ch_half_duty(ch_half_duty), .load_single_ended(load_single_ended),
        .osc_trim_en(osc_trim_en), .osc_trim_code(osc_trim_code), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Outputs are looked at one nanosecond after the edge so the design's updates have landed.
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        chk(name, exp, rd);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        tick(2);
        chk("ch_active_rst", 32'h0000_0000, 32'(ch_active));
        @(posedge pclk);
        presetn <= 1'b1;
        tick(3);
        chk("ch_active_dflt", 32'h0000_0030, 32'(ch_active));
        rchk("grp_rst", pss_pkg::IDX_GRP, 32'h0000_0030);
        rchk("ssp_rst", pss_pkg::IDX_SSP, 32'h0000_0000);
        rchk("trim_rst", pss_pkg::IDX_TRIM, 32'h0000_0082);
        chk("trim_en_rst", 32'h0000_0000, 32'(osc_trim_en));
        chk("irq_rst", 32'h0000_0000, 32'(irq));
    endtask

    task automatic t_group();
        apb(1'b1, pss_pkg::IDX_GRP, 32'h0000_00FF);
        chk("grp_ok", 32'h0000_0000, 32'(err));
        rchk("grp_rsvd", pss_pkg::IDX_GRP, 32'h0000_003F);
        tick(3);
        chk("ch_active_all", 32'h0000_003F, 32'(ch_active));
        apb(1'b1, pss_pkg::IDX_GRP, 32'h0000_0001);
        tick(3);
        chk("ch_active_one", 32'h0000_0001, 32'(ch_active));
        apb(1'b1, pss_pkg::IDX_CTRL, 32'h0000_0001);
        tick(3);
        chk("ch_active_sd", 32'h0000_0000, 32'(ch_active));
        apb(1'b1, pss_pkg::IDX_CTRL, 32'h0000_0000);
        tick(3);
        chk("ch_active_back", 32'h0000_0001, 32'(ch_active));
        apb(1'b1, pss_pkg::IDX_SSP, 32'h0000_0007);
        apb(1'b1, pss_pkg::IDX_GRP, 32'h0000_0003);
        tick(3);
        chk("ch_active_noper", 32'h0000_0003, 32'(ch_active));
        chk("half_noper", 32'h0000_0000, 32'(ch_half_duty));
        grp_v = 6'h03;
    endtask

    // Toggles channel 2 and times how long it is held at half duty.
    task automatic t_period(input logic [7:0] ssp, input int tenths);
        logic [5:0] g0;
        int cnt = 0;
        int p;
        p = tenths * CPT;
        g0 = grp_v;
        grp_v = grp_v ^ 6'h02;
        apb(1'b1, pss_pkg::IDX_SSP, 32'(ssp));
        apb(1'b1, pss_pkg::IDX_GRP, 32'(grp_v));
        tick(4);
        chk("half_during", 32'h0000_0002, 32'(ch_half_duty));
        chk("active_during", 32'(g0 | 6'h02), 32'(ch_active));
        while (ch_half_duty !== 6'h00 && cnt < p + 20) begin
            tick(1);
            cnt++;
        end
        cnt = cnt + 4;
        chk("period_cycles", p, (cnt >= p && cnt <= p + 8) ? p : cnt);
        chk("active_after", 32'(grp_v), 32'(ch_active));
        chk("load_se", 32'(ssp[7]), 32'(load_single_ended));
    endtask

    // Shutdown during a period; the host clears the group first, as advised.
    task automatic t_shutdown();
        int cnt = 0;
        apb(1'b1, pss_pkg::IDX_SSP, 32'h0000_0008);
        apb(1'b1, pss_pkg::IDX_GRP, 32'h0000_0000);
        apb(1'b1, pss_pkg::IDX_CTRL, 32'h0000_0001);
        tick(2);
        chk("half_sd", 32'(grp_v), 32'(ch_half_duty));
        while (ch_active !== 6'h00 && cnt < 700) begin
            tick(1);
            cnt++;
        end
        chk("active_sd", 32'h0000_0000, 32'(ch_active));
        apb(1'b1, pss_pkg::IDX_SSP, 32'h0000_0000);
        apb(1'b1, pss_pkg::IDX_GRP, 32'(grp_v));
        tick(3);
        chk("active_sd_grp", 32'h0000_0000, 32'(ch_active));
        apb(1'b1, pss_pkg::IDX_CTRL, 32'h0000_0000);
        tick(3);
        chk("active_sd_off", 32'(grp_v), 32'(ch_active));
    endtask

    task automatic t_irq();
        rchk("istat_soft", pss_pkg::IDX_ISTAT, 32'h0000_0002);
        chk("irq_set", 32'h0000_0001, 32'(irq));
        apb(1'b1, pss_pkg::IDX_IMASK, 32'h0000_0000);
        tick(2);
        chk("irq_masked", 32'h0000_0000, 32'(irq));
        apb(1'b1, pss_pkg::IDX_IMASK, 32'h0000_0002);
        tick(2);
        chk("irq_unmasked", 32'h0000_0001, 32'(irq));
        apb(1'b1, pss_pkg::IDX_ISTAT, 32'h0000_0002);
        tick(2);
        chk("irq_clr", 32'h0000_0000, 32'(irq));
        rchk("istat_clr", pss_pkg::IDX_ISTAT, 32'h0000_0000);
    endtask

    task automatic t_trim();
        int n = 0;
        apb(1'b1, pss_pkg::IDX_ISTAT, 32'h0000_0003);
        apb(1'b1, pss_pkg::IDX_IMASK, 32'h0000_0001);
        apb(1'b1, pss_pkg::IDX_TRIM, 32'h0000_0000);
        rchk("trim_busy", pss_pkg::IDX_TRIM, 32'h0000_0080);
        do begin
            apb(1'b0, pss_pkg::IDX_TRIM, 32'h0000_0000);
            n++;
        end while (rd[6] !== 1'b1 && n < 20);
        chk("trim_done", 32'h0000_00C0, rd);
        tick(1);
        chk("trim_en", 32'h0000_0001, 32'(osc_trim_en));
        chk("trim_code", 32'h0000_005A, 32'(osc_trim_code));
        chk("irq_trim", 32'h0000_0001, 32'(irq));
        rchk("istat_trim", pss_pkg::IDX_ISTAT, 32'h0000_0001);
        apb(1'b1, pss_pkg::IDX_TRIM, 32'h0000_00FF);
        tick(3);
        rchk("trim_off", pss_pkg::IDX_TRIM, 32'h0000_0082);
        chk("trim_en_off", 32'h0000_0000, 32'(osc_trim_en));
    endtask

    task automatic t_unmapped();
        apb(1'b1, 8'h20, 32'h0000_00FF);
        chk("err_wr", 32'h0000_0001, 32'(err));
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("err_rd", 32'h0000_0001, 32'(err));
        chk("rd_unmapped", 32'h0000_0000, rd);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        t_reset();
        t_group();
        apb(1'b1, pss_pkg::IDX_IMASK, 32'h0000_0002);
        t_period(8'h88, 165);
        t_irq();
        t_period(8'h09, 239);
        t_period(8'h0F, 1257);
        t_period(8'h10, 1646);
        t_period(8'h11, 2394);
        t_shutdown();
        t_trim();
        t_unmapped();
        end_of_test();
    end

    // The timed periods take about 23000 clocks, so this limit only trips on a hang.
    initial begin
        repeat (40000) @(posedge pclk);
        num_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
